// ### src/cal_status_params.svh
// Constants for the calibration store and standard event status block.
// Assumes inclusion by the package and the block; holds definitions only.
`ifndef CAL_STATUS_PARAMS_SVH
`define CAL_STATUS_PARAMS_SVH

// Width of one calibration record
`define CAL_W 32
// Number of calibration areas kept
`define CAL_AREAS 6
// Event flag bit positions
`define EVT_OPC_BIT 0
`define EVT_QUERY_BIT 2
`define EVT_DEVICE_BIT 3
`define EVT_EXEC_BIT 4
`define EVT_CMD_BIT 5
// Bits of the event flags and mask that exist
`define EVT_USED_MASK 8'h3d
// Reset values
`define EVT_ENABLE_RESET 8'h00
`define EVT_FLAGS_RESET 8'h00
// Status byte position of the event summary
`define STB_ESB_BIT 5
// Calibration date length in characters
`define CAL_DATE_CHARS 12
// Error code class limits
`define ERR_CLASS_STEP 10'd100
// Identification text layout
`define IDN_HEAD_CHARS 24
`define IDN_REV_CHARS 3
`define IDN_CHARS 41
// Punctuation used as field separator
`define IDN_SEP 8'h2c

`endif

// ### src/cal_status_pkg.sv
// Types for the calibration store and standard event status block.
// Assumes the constant header is on the include path.
`include "cal_status_params.svh"

package cal_status_pkg;

  // Calibration areas, in storage order
  typedef enum logic [2:0] {
    AREA_WORKING,
    AREA_PRIOR,
    AREA_OLDEST,
    AREA_FACTORY,
    AREA_MASTER,
    AREA_FIRST
  } area_e;

  // Decoded commands and queries
  typedef enum logic [3:0] {
    OP_CAL_STORE,
    OP_CAL_DUMP_Q,
    OP_CAL_COPY,
    OP_COMPACT,
    OP_CLS,
    OP_ESE,
    OP_ESE_Q,
    OP_ESR_Q,
    OP_IDN_Q,
    OP_OPC
  } op_e;

  // One parsed command from the remote controller
  typedef struct packed {
    logic star;                 // Leading asterisk seen
    op_e op;                    // Command or query
    area_e area;                // Source or destination area
    logic [7:0] value;          // Integer argument
    logic [`CAL_W-1:0] cal;     // New calibration record
  } cmd_s;

  // Response byte stream
  typedef struct packed {
    logic [7:0] data;           // Response byte
    logic last;                 // Final byte of the response
  } resp_s;

  // Error report from the parser or the output stage
  typedef struct packed {
    logic [9:0] code;           // Numeric error code
  } err_s;

endpackage

// ### src/cal_store_and_event_status.sv
// Calibration area store and standard event status model.
// Assumes a parser ahead of it delivering decoded commands on clk.
`timescale 1ns/1ps

module cal_store_and_event_status #(
  parameter logic [8*`IDN_HEAD_CHARS-1:0] IDN_HEAD = "MAKERX,MODELX,0,0,000000", // Arbitrary
  parameter logic [8*`IDN_REV_CHARS-1:0] IDN_REV = "1.0" // Arbitrary revision text
) (
  input wire logic clk,                                // 250 MHz clock
  input wire logic rst,                                // Synchronous reset, high
  input wire logic cmd_valid,                          // Command offered
  output logic cmd_ready,                              // Command taken when high
  input wire cal_status_pkg::cmd_s cmd,                // Decoded command
  output logic resp_valid,                             // Response byte offered
  input wire logic resp_ready,                         // Controller takes byte
  output cal_status_pkg::resp_s resp,                  // Response byte
  input wire logic err_valid,                          // Error reported, pulse
  input wire cal_status_pkg::err_s err,                // Error code
  input wire logic cur_err,                            // Current error detected
  input wire logic volt_err,                           // Voltage error detected
  input wire logic ques_cur,                           // Questionable current bit
  input wire logic ques_volt,                          // Questionable voltage bit
  input wire logic ops_pending,                        // Earlier operations running
  input wire logic factory_unlock_pin,                 // Password accepted, from pin
  input wire logic [8*`CAL_DATE_CHARS-1:0] cal_date,   // Calibration date text
  output logic [`CAL_W-1:0] active_cal,                // Working calibration
  output logic [7:0] event_enable_mask,                // Enable mask
  output logic [7:0] standard_event_flags,             // Event flags
  output logic esb,                                    // Status byte bit 5
  output logic status_clear                            // Clear pulse to other status
);

  // Response sequencer states
  typedef enum logic {ST_IDLE, ST_IDN} resp_state_e;

  logic [`CAL_W-1:0] cal_area [`CAL_AREAS]; // Non-volatile calibration areas
  logic unlock_meta;                        // First synchroniser stage
  logic unlock;                             // Synchronised unlock level
  logic fire;                               // Command accepted
  logic common_op;                          // Command is a common one
  logic bad_common;                         // Common command without asterisk
  cal_status_pkg::area_e dump_src;          // Source named by the dump query
  logic dump_armed;                         // Dump seen, copy may follow
  logic copy_go;                            // Copy allowed this cycle
  logic copy_refused;                       // Copy rejected
  logic [7:0] evt_set;                      // Flags raised this cycle
  logic [7:0] evt_clr;                      // Flags cleared this cycle
  logic opc_armed;                          // Waiting for pending work to end
  resp_state_e state;                       // Response sequencer
  logic [5:0] idn_idx;                      // Identification byte index

  // Error class decode, used by the reported error path only
  function automatic logic [7:0] class_bits(input logic [9:0] code);
    logic [7:0] b;
    b = 8'h00;
    if (code >= `ERR_CLASS_STEP && code < 2 * `ERR_CLASS_STEP)
      b[`EVT_CMD_BIT] = 1'b1;
    else if (code >= 2 * `ERR_CLASS_STEP && code < 3 * `ERR_CLASS_STEP)
      b[`EVT_EXEC_BIT] = 1'b1;
    else if (code >= 3 * `ERR_CLASS_STEP && code < 4 * `ERR_CLASS_STEP)
      b[`EVT_DEVICE_BIT] = 1'b1;
    else if (code >= 4 * `ERR_CLASS_STEP && code < 5 * `ERR_CLASS_STEP)
      b[`EVT_QUERY_BIT] = 1'b1;
    return b;
  endfunction

  // Identification text: head, date, revision, comma separated
  function automatic logic [7:0] idn_byte(input logic [5:0] idx);
    logic [7:0] b;
    b = `IDN_SEP;
    if (idx < 6'(`IDN_HEAD_CHARS))
      b = IDN_HEAD[8*(`IDN_HEAD_CHARS-1-idx) +: 8];
    else if (idx > 6'(`IDN_HEAD_CHARS) && idx <= 6'(`IDN_HEAD_CHARS + `CAL_DATE_CHARS))
      b = cal_date[8*(`IDN_HEAD_CHARS + `CAL_DATE_CHARS - idx) +: 8];
    else if (idx > 6'(`IDN_HEAD_CHARS + `CAL_DATE_CHARS + 1))
      b = IDN_REV[8*(`IDN_CHARS - 1 - idx) +: 8];
    return b;
  endfunction

  // Unlock pin synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      unlock_meta <= 1'b0;
      unlock <= 1'b0;
    end
    else
    begin
      unlock_meta <= factory_unlock_pin;
      unlock <= unlock_meta;
    end
  end

  // Command decode
  always_comb
  begin
    fire = cmd_valid && cmd_ready;
    common_op = cmd.op inside {cal_status_pkg::OP_CLS, cal_status_pkg::OP_ESE,
      cal_status_pkg::OP_ESE_Q, cal_status_pkg::OP_ESR_Q, cal_status_pkg::OP_IDN_Q,
      cal_status_pkg::OP_OPC};
    bad_common = fire && common_op && !cmd.star;
    copy_refused = fire && cmd.op == cal_status_pkg::OP_CAL_COPY
      && (!dump_armed || (cmd.area == cal_status_pkg::AREA_FACTORY && !unlock));
    copy_go = fire && cmd.op == cal_status_pkg::OP_CAL_COPY && !copy_refused;
  end

  // Source area held between dump query and copy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dump_src <= cal_status_pkg::AREA_WORKING;
      dump_armed <= 1'b0;
    end
    else if (fire && cmd.op == cal_status_pkg::OP_CAL_DUMP_Q)
    begin
      dump_src <= cmd.area;
      dump_armed <= 1'b1;
    end
  end

  // Calibration areas; reset leaves them alone as they are non-volatile
  always_ff @(posedge clk)
  begin
    if (fire && cmd.op == cal_status_pkg::OP_COMPACT)
    begin
      // Compaction drops every stored record; a store or copy drops only those it overwrites
      for (int i = 0; i < `CAL_AREAS; i++)
        cal_area[i] <= '0;
    end
    else if (fire && cmd.op == cal_status_pkg::OP_CAL_STORE)
    begin
      cal_area[cal_status_pkg::AREA_OLDEST] <= cal_area[cal_status_pkg::AREA_PRIOR];
      cal_area[cal_status_pkg::AREA_PRIOR] <= cal_area[cal_status_pkg::AREA_WORKING];
      cal_area[cal_status_pkg::AREA_WORKING] <= cmd.cal;
    end
    else if (copy_go && cmd.area == cal_status_pkg::AREA_WORKING)
    begin
      // Old values are read before any is replaced
      cal_area[cal_status_pkg::AREA_OLDEST] <= cal_area[cal_status_pkg::AREA_PRIOR];
      cal_area[cal_status_pkg::AREA_PRIOR] <= cal_area[cal_status_pkg::AREA_WORKING];
      cal_area[cal_status_pkg::AREA_WORKING] <= cal_area[dump_src];
    end
    else if (copy_go)
    begin
      cal_area[cmd.area] <= cal_area[dump_src];
    end
  end

  // Working area drives operation
  assign active_cal = cal_area[cal_status_pkg::AREA_WORKING];

  // Enable mask; unused positions never store
  always_ff @(posedge clk)
  begin
    if (rst)
      event_enable_mask <= `EVT_ENABLE_RESET;
    else if (fire && cmd.star && cmd.op == cal_status_pkg::OP_ESE)
      event_enable_mask <= cmd.value & `EVT_USED_MASK;
  end

  // Flag set and clear terms
  always_comb
  begin
    evt_set = 8'h00;
    if (err_valid)
      evt_set = class_bits(err.code);
    if (bad_common)
      evt_set[`EVT_CMD_BIT] = 1'b1;
    if (copy_refused)
      evt_set[`EVT_EXEC_BIT] = 1'b1;
    if ((cur_err && ques_cur) || (volt_err && ques_volt))
      evt_set[`EVT_DEVICE_BIT] = 1'b1;
    if (opc_armed && !ops_pending)
      evt_set[`EVT_OPC_BIT] = 1'b1;
    evt_clr = 8'h00;
    if (fire && cmd.star && (cmd.op == cal_status_pkg::OP_CLS
        || cmd.op == cal_status_pkg::OP_ESR_Q))
      evt_clr = 8'hff;
    if (fire && cmd.star && cmd.op == cal_status_pkg::OP_OPC)
      evt_clr[`EVT_OPC_BIT] = 1'b1;
  end

  // Event flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      standard_event_flags <= `EVT_FLAGS_RESET;
    else
      standard_event_flags <= ((standard_event_flags & ~evt_clr) | evt_set)
        & `EVT_USED_MASK;
  end

  // Operation complete tracking
  always_ff @(posedge clk)
  begin
    if (rst)
      opc_armed <= 1'b0;
    else if (fire && cmd.star && cmd.op == cal_status_pkg::OP_OPC)
      opc_armed <= 1'b1;
    else if (fire && cmd.star && cmd.op == cal_status_pkg::OP_CLS)
      opc_armed <= 1'b0;
    else if (opc_armed && !ops_pending)
      opc_armed <= 1'b0;
  end

  // Event summary into the status byte
  assign esb = |(standard_event_flags & event_enable_mask);

  // Pulse telling the other status registers and error queue to clear
  always_ff @(posedge clk)
  begin
    if (rst)
      status_clear <= 1'b0;
    else
      status_clear <= fire && cmd.star && cmd.op == cal_status_pkg::OP_CLS;
  end

  // Commands wait while a response is outstanding
  assign cmd_ready = !resp_valid && state == ST_IDLE;

  // Response sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      idn_idx <= '0;
      resp_valid <= 1'b0;
      resp <= '0;
    end
    else if (resp_valid && !resp_ready)
    begin
      // Hold the byte until taken
      resp_valid <= 1'b1;
    end
    else if (state == ST_IDN)
    begin
      resp_valid <= 1'b1;
      resp.data <= idn_byte(idn_idx);
      resp.last <= idn_idx == 6'(`IDN_CHARS - 1);
      idn_idx <= idn_idx + 6'd1;
      if (idn_idx == 6'(`IDN_CHARS - 1))
        state <= ST_IDLE;
    end
    else if (fire && cmd.star && cmd.op == cal_status_pkg::OP_ESE_Q)
    begin
      resp_valid <= 1'b1;
      resp <= '{data: event_enable_mask, last: 1'b1};
    end
    else if (fire && cmd.star && cmd.op == cal_status_pkg::OP_ESR_Q)
    begin
      resp_valid <= 1'b1;
      resp <= '{data: standard_event_flags, last: 1'b1};
    end
    else if (fire && cmd.op == cal_status_pkg::OP_CAL_DUMP_Q)
    begin
      resp_valid <= 1'b1;
      resp <= '{data: {5'h00, cmd.area}, last: 1'b1};
    end
    else if (fire && cmd.star && cmd.op == cal_status_pkg::OP_IDN_Q)
    begin
      state <= ST_IDN;
      idn_idx <= '0;
      resp_valid <= 1'b0;
    end
    else
    begin
      resp_valid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_ESE_STORE: assert property (fire && cmd.star && cmd.op == cal_status_pkg::OP_ESE
    |=> event_enable_mask == ($past(cmd.value) & 8'h3d)) else $error("mask not stored");
  AST_UNUSED_ZERO: assert property (standard_event_flags[7:6] == 2'b00
    && !standard_event_flags[1] && event_enable_mask[7:6] == 2'b00)
    else $error("unused bit set");
  AST_ESR_READ: assert property (fire && cmd.star && cmd.op == cal_status_pkg::OP_ESR_Q
    && evt_set == 8'h00 |=> standard_event_flags == 8'h00
    && resp.data == $past(standard_event_flags)) else $error("flag read wrong");
  AST_CLS_KEEP: assert property (fire && cmd.star && cmd.op == cal_status_pkg::OP_CLS
    |=> event_enable_mask == $past(event_enable_mask) && status_clear)
    else $error("clear touched mask");
  AST_CLASS_ONE: assert property (err_valid && err.code >= 10'd100 && err.code < 10'd200
    |=> standard_event_flags[5]) else $error("class 1 not flagged");
  AST_STORE_SHIFT: assert property (fire && cmd.op == cal_status_pkg::OP_CAL_STORE
    |=> cal_area[1] == $past(cal_area[0]) && cal_area[2] == $past(cal_area[1])
    && active_cal == $past(cmd.cal)) else $error("store rotation wrong");
  AST_FACTORY_LOCK: assert property (fire && cmd.op == cal_status_pkg::OP_CAL_COPY
    && cmd.area == cal_status_pkg::AREA_FACTORY && !unlock
    |=> $stable(cal_area[3]) && standard_event_flags[4]) else $error("factory written");
  AST_OPC_WAIT: assert property (opc_armed && ops_pending
    |=> !$rose(standard_event_flags[0])) else $error("complete set early");
  AST_NO_STAR: assert property (bad_common |=> standard_event_flags[5])
    else $error("missing asterisk not flagged");
  AST_ESB_MASK: assert property (event_enable_mask == 8'h00 |-> !esb)
    else $error("summary without enable");
  AST_IDN_LEN: assert property (fire && cmd.star && cmd.op == cal_status_pkg::OP_IDN_Q
    |-> ##[2:200] (resp_valid && resp.last)) else $error("ident never ends");
  // Answers, area moves and completion tracking
  AST_ESE_QUERY: assert property (fire && cmd.star && cmd.op == cal_status_pkg::OP_ESE_Q
    |=> resp_valid && resp.last && resp.data == $past(event_enable_mask))
    else $error("mask answer wrong");
  AST_DUMP_ANSWER: assert property (fire && cmd.op == cal_status_pkg::OP_CAL_DUMP_Q
    |=> resp_valid && resp.data == {5'h00, $past(cmd.area)}) else $error("dump answer wrong");
  AST_COPY_WORK: assert property (copy_go && cmd.area == cal_status_pkg::AREA_WORKING
    |=> cal_area[1] == $past(cal_area[0]) && cal_area[2] == $past(cal_area[1])
    && active_cal == $past(cal_area[dump_src])) else $error("copy rotation wrong");
  AST_OPC_SET: assert property (opc_armed && !ops_pending |=> standard_event_flags[0])
    else $error("complete not set");
  AST_CLS_DISARM: assert property (fire && cmd.star && cmd.op == cal_status_pkg::OP_CLS
    |=> !opc_armed) else $error("clear left complete armed");

  // Main scenarios reached
  COV_STORE: cover property (fire && cmd.op == cal_status_pkg::OP_CAL_STORE);
  COV_COPY_WORK: cover property (copy_go && cmd.area == cal_status_pkg::AREA_WORKING);
  COV_IDN_DONE: cover property (resp_valid && resp_ready && resp.last && state == ST_IDLE);
  COV_ESB: cover property (esb);
  COV_FACTORY: cover property (copy_go && cmd.area == cal_status_pkg::AREA_FACTORY);

endmodule

// ### sim/remote_ctrl_model.sv
// Remote controller model: offers parsed commands, takes response bytes, gives the password.
// Assumes the block's command port contract and a single clock domain.
`timescale 1ns/1ps

module remote_ctrl_model (
  input wire logic clk,                       // Block clock
  input wire logic cmd_ready,                 // Block can take a command
  input wire logic resp_valid,                // Response byte offered
  input wire cal_status_pkg::resp_s resp,     // Response byte
  output logic cmd_valid,                     // Command offered
  output cal_status_pkg::cmd_s cmd,           // Command fields
  output logic resp_ready,                    // Byte taken
  output logic factory_unlock_pin             // Password accepted
);
  logic hang; // A bounded wait ran out

  // Idle levels at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
    resp_ready = 1'b0;
    factory_unlock_pin = 1'b0;
    hang = 1'b0;
  end

  // Offer one command and hold it until the edge that takes it
  task automatic send(input cal_status_pkg::op_e op, input logic star,
    input cal_status_pkg::area_e area, input logic [7:0] value, input logic [31:0] cal);
    int n;
    begin
      n = 0;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd = '{star: star, op: op, area: area, value: value, cal: cal};
      // Ready comes from registers, so its settled value holds up to the next edge
      while (!cmd_ready && n < 50)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      hang |= !cmd_ready;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      // Released lines do not keep the last value
      cmd = ~cmd;
    end
  endtask

  // Take one response byte, optionally after a stall; ready drops after the last byte
  task automatic get(output logic [7:0] d, output logic l, input int stall);
    int n;
    begin
      n = 0;
      repeat (stall) @(posedge clk);
      if (stall > 0)
        #1;
      while (!resp_valid && n < 60)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      hang |= !resp_valid;
      // The byte stands until the edge that takes it
      resp_ready = 1'b1;
      d = resp.data;
      l = resp.last;
      @(posedge clk);
      #1;
      if (l)
        resp_ready = 1'b0;
    end
  endtask

  // Raise the unlock pin only for a password of legal form
  task automatic give_password(input string pw);
    bit a, d, p, bad;
    begin
      a = 0;
      d = 0;
      p = 0;
      bad = (pw.len() < 6) || (pw.len() > 20);
      foreach (pw[i])
      begin
        if (pw[i] >= "A" && pw[i] <= "Z")
          a = 1;
        else if (pw[i] >= "0" && pw[i] <= "9")
          d = 1;
        else if (pw[i] inside {"!", "@", "#", "$", "%", "^", "&", "*"})
          p = 1;
        else
          bad = 1;
      end
      factory_unlock_pin = !bad && a && d && p;
    end
  endtask
endmodule

// ### sim/cal_store_and_event_status_test.sv
// Self-checking bench for the calibration store and event status block.
// Assumes the remote controller model drives the command and response ports.
`timescale 1ns/1ps

module cal_store_and_event_status_test;
  localparam logic [191:0] IDN_H = "QRSTUV,WXYZ01,5,6,987654"; // Arbitrary text
  localparam logic [23:0] IDN_R = "3.2"; // Arbitrary revision
  localparam logic [95:0] DATE = "2004-12-21XY"; // Calibration date text
  logic clk, rst, cmd_valid, cmd_ready, resp_valid, resp_ready, err_valid;
  logic cur_err, volt_err, ques_cur, ques_volt, ops_pending, unlock, esb, status_clear;
  cal_status_pkg::cmd_s cmd; // Command to the block
  cal_status_pkg::resp_s resp; // Response byte
  cal_status_pkg::err_s err; // Error code
  logic [31:0] active_cal; // Working record
  logic [7:0] mask, flags; // Enable mask and event flags
  int fail_count, num_checks;

  cal_store_and_event_status #(.IDN_HEAD(IDN_H), .IDN_REV(IDN_R)) dut (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp(resp), .err_valid(err_valid), .err(err), .cur_err(cur_err),
    .volt_err(volt_err), .ques_cur(ques_cur), .ques_volt(ques_volt), .ops_pending(ops_pending),
    .factory_unlock_pin(unlock), .cal_date(DATE), .active_cal(active_cal),
    .event_enable_mask(mask), .standard_event_flags(flags), .esb(esb),
    .status_clear(status_clear));

  remote_ctrl_model ctrl (.clk(clk), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp(resp), .cmd_valid(cmd_valid), .cmd(cmd), .resp_ready(resp_ready),
    .factory_unlock_pin(unlock));

  // Free running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hung handshake ends the run
  always @(posedge clk)
    if (ctrl.hang === 1'b1)
    begin
      fail_count++;
      final_report();
    end

  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      num_checks++;
      if (got !== exp)
      begin
        $display("ERROR %s expected %0h seen %0h", name, exp, got);
        fail_count++;
      end
    end
  endtask

  // Wait n edges, then step past the edge
  task automatic tick(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  // Send a command; common ones carry the asterisk
  task automatic cmdo(input cal_status_pkg::op_e op, input logic [2:0] a,
    input logic [7:0] v, input logic [31:0] c);
    ctrl.send(op, op >= cal_status_pkg::OP_CLS, cal_status_pkg::area_e'(a), v, c);
  endtask

  // Query with a single byte answer
  task automatic ask(input cal_status_pkg::op_e op, input logic [2:0] a,
    input logic [7:0] exp, input int stall);
    logic [7:0] d;
    logic l;
    begin
      cmdo(op, a, 8'h00, 32'h0);
      ctrl.get(d, l, stall);
      chk("answer", {exp, 1'b1}, {d, l});
    end
  endtask

  // Name a source, then a destination
  task automatic copy(input logic [2:0] src, input logic [2:0] dst);
    begin
      ask(cal_status_pkg::OP_CAL_DUMP_Q, src, {5'h00, src}, 2);
      cmdo(cal_status_pkg::OP_CAL_COPY, dst, 8'h00, 32'h0);
    end
  endtask

  // One-cycle error or fault pulse
  task automatic ev(input logic [9:0] code, input logic c, input logic v);
    begin
      err_valid = code != 10'h000;
      err.code = code;
      cur_err = c;
      volt_err = v;
      tick(1);
      err_valid = 1'b0;
      cur_err = 1'b0;
      volt_err = 1'b0;
    end
  endtask

  // Store rotation and copies between areas
  task automatic t_store;
    begin
      cmdo(cal_status_pkg::OP_COMPACT, 3'h0, 8'h00, 32'h0);
      chk("compact", 32'h0, active_cal);
      for (int i = 1; i <= 3; i++)
        cmdo(cal_status_pkg::OP_CAL_STORE, 3'h0, 8'h00, 32'(i) * 32'h11);
      chk("store", 32'h33, active_cal);
      copy(3'h2, 3'h0);
      chk("copy oldest", 32'h11, active_cal);
      copy(3'h1, 3'h0);
      chk("copy prior", 32'h33, active_cal);
      copy(3'h1, 3'h0);
      chk("copy prior again", 32'h11, active_cal);
      copy(3'h4, 3'h0);
      chk("master kept", 32'h0, active_cal);
    end
  endtask

  // Factory area protection and the password pin
  task automatic t_factory;
    begin
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h00, 0);
      copy(3'h0, 3'h3);
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h10, 0);
      ctrl.give_password("PASS12");
      tick(3);
      copy(3'h0, 3'h3);
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h10, 0);
      ctrl.give_password("CAL#2024");
      tick(3);
      cmdo(cal_status_pkg::OP_CAL_STORE, 3'h0, 8'h00, 32'h44);
      copy(3'h0, 3'h3);
      cmdo(cal_status_pkg::OP_CAL_STORE, 3'h0, 8'h00, 32'h55);
      copy(3'h3, 3'h0);
      chk("factory copy", 32'h44, active_cal);
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h00, 0);
      ctrl.give_password("A1!");
      tick(3);
      copy(3'h0, 3'h3);
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h10, 0);
    end
  endtask

  // Error classes, enable mask, summary bit, clear and asterisk
  task automatic t_events;
    logic [9:0] codes [4] = '{10'h065, 10'h0fa, 10'h18f, 10'h194};
    logic [7:0] bits [4] = '{8'h20, 8'h10, 8'h08, 8'h04};
    begin
      cmdo(cal_status_pkg::OP_ESE, 3'h0, 8'hff, 32'h0);
      chk("mask", 8'h3d, mask);
      ask(cal_status_pkg::OP_ESE_Q, 3'h0, 8'h3d, 1);
      foreach (codes[i])
      begin
        ev(codes[i], 1'b0, 1'b0);
        chk("esb set", 1'b1, esb);
        ask(cal_status_pkg::OP_ESR_Q, 3'h0, bits[i], 0);
        chk("flags read", 8'h00, flags);
      end
      ev(10'h000, 1'b1, 1'b1);
      chk("fault alone", 8'h00, flags);
      ques_volt = 1'b1;
      ev(10'h000, 1'b0, 1'b1);
      chk("volt fault", 8'h08, flags);
      ques_volt = 1'b0;
      ques_cur = 1'b1;
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h08, 0);
      ev(10'h000, 1'b1, 1'b0);
      chk("cur fault", 8'h08, flags);
      ques_cur = 1'b0;
      cmdo(cal_status_pkg::OP_ESE, 3'h0, 8'h10, 32'h0);
      chk("esb masked", 1'b0, esb);
      cmdo(cal_status_pkg::OP_ESE, 3'h0, 8'h08, 32'h0);
      chk("esb enabled", 1'b1, esb);
      cmdo(cal_status_pkg::OP_CLS, 3'h0, 8'h00, 32'h0);
      chk("clear pulse", 1'b1, status_clear);
      chk("flags cleared", 8'h00, flags);
      chk("mask kept", 8'h08, mask);
      ctrl.send(cal_status_pkg::OP_ESE, 1'b0, cal_status_pkg::AREA_WORKING, 8'h01, 32'h0);
      chk("mask no star", 8'h08, mask);
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h20, 0);
    end
  endtask

  // Completion bit waits for pending work; clear disarms it
  task automatic t_opc;
    begin
      ops_pending = 1'b1;
      cmdo(cal_status_pkg::OP_OPC, 3'h0, 8'h00, 32'h0);
      tick(3);
      chk("busy", 8'h00, flags);
      ops_pending = 1'b0;
      tick(2);
      ask(cal_status_pkg::OP_ESR_Q, 3'h0, 8'h01, 0);
      ops_pending = 1'b1;
      cmdo(cal_status_pkg::OP_OPC, 3'h0, 8'h00, 32'h0);
      cmdo(cal_status_pkg::OP_CLS, 3'h0, 8'h00, 32'h0);
      ops_pending = 1'b0;
      tick(3);
      chk("disarmed", 8'h00, flags);
    end
  endtask

  // Identification stream byte by byte
  task automatic t_idn;
    logic [8*41-1:0] exp;
    logic [7:0] d;
    logic l;
    begin
      exp = {IDN_H, 8'h2c, DATE, 8'h2c, IDN_R};
      cmdo(cal_status_pkg::OP_IDN_Q, 3'h0, 8'h00, 32'h0);
      for (int i = 0; i < 41; i++)
      begin
        ctrl.get(d, l, 0);
        chk("id byte", {exp[8*(40-i) +: 8], i == 40}, {d, l});
      end
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    err_valid = 1'b0;
    err = '0;
    cur_err = 1'b0;
    volt_err = 1'b0;
    ques_cur = 1'b0;
    ques_volt = 1'b0;
    ops_pending = 1'b0;
    fail_count = 0;
    num_checks = 0;
    tick(4);
    rst = 1'b0;
    chk("reset", 12'h000, {mask, flags[3:0]});
    chk("reset ready", 2'h2, {cmd_ready, esb});
    t_store();
    t_factory();
    t_events();
    t_opc();
    rst = 1'b1; // Mid-run reset keeps the areas
    tick(2);
    rst = 1'b0;
    chk("reset mask", 8'h00, mask);
    chk("reset keeps cal", 32'h44, active_cal);
    t_idn();
    final_report();
  end
endmodule
